// File: core/cpu_arith_logic_shift_unit.sv
// integer datapath: general registers, arithmetic, logic and shift operations
`timescale 1ns/10ps
module cpu_arith_logic_shift_unit (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic reqValid,
   input wire alu_pkg::req_type req,
   input wire logic [7:0] memByte,
   input wire alu_pkg::load_type load,
   input wire logic [2:0] readIdx,
   output logic done,
   output logic refused,
   output alu_pkg::flags_type condition_code_register,
   output logic [31:0] readData,
   output alu_pkg::mem_type memWr
);
   import alu_pkg::*;

   logic [31:0] regs_q [REG_COUNT];
   logic [31:0] regs_d [REG_COUNT];
   flags_type ccr_q, ccr_d;
   logic done_q, done_d, refused_q, refused_d;
   logic [31:0] readData_q, readData_d;
   mem_type memWr_q, memWr_d;

   logic [2:0] dstIdx, srcIdx;
   logic [31:0] dstWide, srcWide, opA, opB, res, sh;
   logic [36:0] ar;
   size_type upSize;
   logic legal, writeBack, wideWrite, shC;
   logic [7:0] adj;
   logic [31:0] product;
   logic [15:0] quotient, remainder;
   logic divZero, isSigned;

   // =====================================================
   // size helpers
   function automatic logic [4:0] topBit(size_type s);
      case (s)
         size_byte: return 5'h07;
         size_word: return 5'h0F;
         default: return 5'h1F;
      endcase
   endfunction

   function automatic logic [31:0] sizeMask(size_type s);
      case (s)
         size_byte: return MASK_BYTE;
         size_word: return MASK_WORD;
         default: return MASK_LONG;
      endcase
   endfunction

   function automatic logic [31:0] pick(size_type s, logic [3:0] idx, logic [31:0] w);
      case (s)
         size_byte: return idx[3] ? {24'h00_0000, w[7:0]} : {24'h00_0000, w[15:8]};
         size_word: return idx[3] ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
         default: return w;
      endcase
   endfunction

   function automatic logic [31:0] place(size_type s, logic [3:0] idx, logic [31:0] w,
                                         logic [31:0] v);
      case (s)
         size_byte: return idx[3] ? {w[31:8], v[7:0]} : {w[31:16], v[7:0], w[7:0]};
         size_word: return idx[3] ? {v[15:0], w[15:0]} : {w[31:16], v[15:0]};
         default: return v;
      endcase
   endfunction

   // returns {h,n,z,v,c,result}
   function automatic logic [36:0] arith(size_type s, logic [31:0] a, logic [31:0] b,
                                         logic cin, logic sub);
      logic [32:0] sum, low;
      logic [31:0] r, hm;
      logic [4:0] tb;
      flags_type f;
      tb = topBit(s);
      hm = sizeMask(s) >> 4;
      sum = sub ? ({1'b0, a} - {1'b0, b} - 33'(cin)) : ({1'b0, a} + {1'b0, b} + 33'(cin));
      low = sub ? ({1'b0, a & hm} - {1'b0, b & hm} - 33'(cin))
                : ({1'b0, a & hm} + {1'b0, b & hm} + 33'(cin));
      r = sum[31:0] & sizeMask(s);
      f.h = low[tb - 5'h03];
      f.c = sum[6'(tb) + 6'h01];
      f.n = r[tb];
      f.z = (r == 32'h0000_0000);
      f.v = sub ? ((a[tb] != b[tb]) && (r[tb] != a[tb]))
                : ((a[tb] == b[tb]) && (r[tb] != a[tb]));
      return {f, r};
   endfunction

   // =====================================================
   // operand fetch and multiply/divide
   assign dstIdx = req.dst[2:0];
   assign srcIdx = req.src[2:0];
   assign dstWide = regs_q[dstIdx];
   assign srcWide = regs_q[srcIdx];
   assign upSize = (req.size == size_byte) ? size_word : size_long;
   assign opA = pick(req.size, req.dst, dstWide);
   assign opB = req.useImm ? (req.imm & sizeMask(req.size)) : pick(req.size, req.src, srcWide);
   assign isSigned = (req.op == signed_multiply_op) || (req.op == signed_divide_op);

   mul_div_unit mulDiv (
      .signedMode(isSigned),
      .wordMode(req.size == size_word),
      .left(pick(upSize, req.dst, dstWide)),
      .right(opB[15:0]),
      .product(product),
      .quotient(quotient),
      .remainder(remainder),
      .divZero(divZero)
   );

   // =====================================================
   // legality of one request
   always_comb begin
      case (req.op)
         add_with_carry_op, sub_with_carry_op, decimal_adjust_add_op,
         decimal_adjust_sub_op: legal = (req.size == size_byte);
         increment_op, decrement_op: legal = (req.count == 3'h1) ||
            ((req.count == 3'h2) && (req.size != size_byte));
         address_add_op, address_sub_op: legal = (req.size == size_long) &&
            ((req.count == 3'h1) || (req.count == 3'h2) || (req.count == 3'h4));
         unsigned_multiply_op, signed_multiply_op: legal = (req.size != size_long);
         unsigned_divide_op, signed_divide_op: legal = (req.size != size_long) && !divZero;
         zero_extend_op, sign_extend_op: legal = (req.size != size_byte);
         test_and_set_op: legal = (req.size == size_byte) && ((dstIdx == 3'h0) ||
            (dstIdx == 3'h1) || (dstIdx == 3'h4) || (dstIdx == 3'h5));
         arith_left_shift_op, arith_right_shift_op, logic_left_shift_op,
         logic_right_shift_op, rotate_left_op, rotate_right_op, rotate_left_carry_op,
         rotate_right_carry_op: legal = (req.count == 3'h1) || (req.count == 3'h2);
         default: legal = 1'b1;
      endcase
   end

   // =====================================================
   // shift and rotate, one or two steps
   always_comb begin
      logic [4:0] tb;
      logic msb;
      tb = topBit(req.size);
      msb = 1'b0;
      sh = opA;
      shC = ccr_q.c;
      for (int i = 0; i < 2; i++) begin
         if (i < int'(req.count)) begin
            msb = sh[tb];
            case (req.op)
               arith_left_shift_op, logic_left_shift_op: begin
                  shC = msb;
                  sh = (sh << 1) & sizeMask(req.size);
               end
               arith_right_shift_op: begin
                  shC = sh[0];
                  sh = (sh >> 1) | (32'(msb) << tb);
               end
               logic_right_shift_op: begin
                  shC = sh[0];
                  sh = sh >> 1;
               end
               rotate_left_op: begin
                  shC = msb;
                  sh = ((sh << 1) | 32'(msb)) & sizeMask(req.size);
               end
               rotate_right_op: begin
                  shC = sh[0];
                  sh = (sh >> 1) | (32'(sh[0]) << tb);
               end
               rotate_left_carry_op: begin
                  sh = ((sh << 1) | 32'(shC)) & sizeMask(req.size);
                  shC = msb;
               end
               default: begin
                  sh = (sh >> 1) | (32'(shC) << tb);
                  shC = opA[i];
               end
            endcase
         end
      end
   end

   // =====================================================
   // result, flags and register write
   always_comb begin
      ar = arith(req.size, opA, opB, 1'b0, 1'b0);
      res = ar[31:0];
      ccr_d = ccr_q;
      writeBack = 1'b1;
      wideWrite = 1'b0;
      adj = 8'h00;
      memWr_d = '0;
      case (req.op)
         add_op, sub_op, compare_op: begin
            ar = arith(req.size, opA, opB, 1'b0, req.op != add_op);
            res = ar[31:0];
            ccr_d = ar[36:32];
            writeBack = (req.op != compare_op);
         end
         add_with_carry_op, sub_with_carry_op: begin
            ar = arith(req.size, opA, opB, ccr_q.c, req.op == sub_with_carry_op);
            res = ar[31:0];
            ccr_d = ar[36:32];
            ccr_d.z = ar[34] & ccr_q.z;
         end
         increment_op, decrement_op, address_add_op, address_sub_op: begin
            ar = arith(req.size, opA, {29'h0, req.count}, 1'b0,
                       (req.op == decrement_op) || (req.op == address_sub_op));
            res = ar[31:0];
            if ((req.op == increment_op) || (req.op == decrement_op)) begin
               ccr_d.n = ar[35];
               ccr_d.z = ar[34];
               ccr_d.v = ar[33];
            end
         end
         negate_op: begin
            ar = arith(req.size, 32'h0000_0000, opA, 1'b0, 1'b1);
            res = ar[31:0];
            ccr_d = ar[36:32];
         end
         decimal_adjust_add_op, decimal_adjust_sub_op: begin
            if (ccr_q.h || ((req.op == decimal_adjust_add_op) && (opA[3:0] > BCD_DIGIT_MAX)))
               adj = BCD_LOW_ADJ;
            if (ccr_q.c || ((req.op == decimal_adjust_add_op) && (opA[7:0] > BCD_BYTE_MAX))) begin
               adj = adj | BCD_HIGH_ADJ;
               ccr_d.c = 1'b1;
            end
            res = {24'h00_0000, (req.op == decimal_adjust_add_op) ? opA[7:0] + adj
                                                                : opA[7:0] - adj};
            ccr_d.n = res[7];
            ccr_d.z = (res[7:0] == 8'h00);
         end
         unsigned_multiply_op, signed_multiply_op: begin
            res = product;
            wideWrite = 1'b1;
            if (isSigned) begin
               ccr_d.n = res[topBit(upSize)];
               ccr_d.z = (res == 32'h0000_0000);
            end
         end
         unsigned_divide_op, signed_divide_op: begin
            res = (req.size == size_byte) ? {16'h0000, remainder[7:0], quotient[7:0]}
                                          : {remainder, quotient};
            wideWrite = 1'b1;
            ccr_d.n = isSigned ? (opB[topBit(req.size)] ^ opA[topBit(req.size)])
                               : opB[topBit(req.size)];
            ccr_d.z = 1'b0;
         end
         zero_extend_op, sign_extend_op: begin
            if (req.size == size_word)
               res = {16'h0000, {8{(req.op == sign_extend_op) & opA[7]}}, opA[7:0]};
            else
               res = {{16{(req.op == sign_extend_op) & opA[15]}}, opA[15:0]};
            ccr_d.n = res[topBit(req.size)];
            ccr_d.z = (res == 32'h0000_0000);
            ccr_d.v = 1'b0;
         end
         test_and_set_op: begin
            writeBack = 1'b0;
            ccr_d.n = memByte[TAS_BIT];
            ccr_d.z = (memByte == 8'h00);
            ccr_d.v = 1'b0;
            memWr_d.we = legal;
            memWr_d.addr = dstWide;
            memWr_d.data = memByte | TAS_SET_MASK;
         end
         and_op, or_op, xor_op, not_op: begin
            case (req.op)
               and_op: res = opA & opB;
               or_op: res = opA | opB;
               xor_op: res = opA ^ opB;
               default: res = ~opA & sizeMask(req.size);
            endcase
            ccr_d.n = res[topBit(req.size)];
            ccr_d.z = (res == 32'h0000_0000);
            ccr_d.v = 1'b0;
         end
         default: begin
            res = sh;
            ccr_d.n = sh[topBit(req.size)];
            ccr_d.z = (sh == 32'h0000_0000);
            ccr_d.v = (req.op == arith_left_shift_op) &&
                      (sh[topBit(req.size)] != opA[topBit(req.size)]);
            ccr_d.c = shC;
         end
      endcase
      regs_d = regs_q;
      if (load.en)
         regs_d[load.idx] = load.data;
      if (reqValid && legal && writeBack)
         regs_d[dstIdx] = wideWrite ? place(upSize, req.dst, dstWide, res)
                                    : place(req.size, req.dst, dstWide, res);
      if (!(reqValid && legal)) begin
         ccr_d = ccr_q;
         memWr_d = '0;
      end
      done_d = reqValid && legal;
      refused_d = reqValid && !legal;
      readData_d = regs_q[readIdx];
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int i = 0; i < REG_COUNT; i++) regs_q[i] <= REG_RESET;
         ccr_q <= FLAGS_RESET;
         done_q <= 1'b0;
         refused_q <= 1'b0;
         readData_q <= REG_RESET;
         memWr_q <= '0;
      end else begin
         regs_q <= regs_d;
         ccr_q <= ccr_d;
         done_q <= done_d;
         refused_q <= refused_d;
         readData_q <= readData_d;
         memWr_q <= memWr_d;
      end
   end

   assign done = done_q;
   assign refused = refused_q;
   assign condition_code_register = ccr_q;
   assign readData = readData_q;
   assign memWr = memWr_q;

   // =====================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_answer_one_cycle: assert property (reqValid |=> (done_q != refused_q))
      else $error("request not answered next cycle");
   a_compare_no_store: assert property (reqValid && legal && !load.en
      && req.op == compare_op |=> regs_q[$past(dstIdx)] == $past(dstWide))
      else $error("compare changed a register");
   a_not_long_inverts: assert property (reqValid && req.op == not_op
      && req.size == size_long && !load.en |=> regs_q[$past(dstIdx)] == ~$past(dstWide))
      else $error("complement result wrong");
   a_neg_long_value: assert property (reqValid && req.op == negate_op
      && req.size == size_long && !load.en
      |=> regs_q[$past(dstIdx)] == 32'h0000_0000 - $past(dstWide))
      else $error("negate result wrong");
   a_byte_keeps_upper: assert property (reqValid && legal && req.size == size_byte
      && req.op == add_op && !load.en
      |=> regs_q[$past(dstIdx)][31:16] == $past(dstWide[31:16]))
      else $error("byte add disturbed upper bits");
   a_logic_flags: assert property (reqValid && req.op == and_op
      |=> !ccr_q.v && ccr_q.c == $past(ccr_q.c))
      else $error("logic flags wrong");
   a_tas_sets_bit: assert property (reqValid && legal && req.op == test_and_set_op
      |=> memWr_q.we && memWr_q.data[7] && memWr_q.addr == $past(dstWide))
      else $error("test-and-set write wrong");
   a_tas_reg_limit: assert property (memWr_q.we
      |-> $past(dstIdx) inside {3'h0, 3'h1, 3'h4, 3'h5})
      else $error("test-and-set used a forbidden register");
   a_inc_byte_one: assert property (reqValid && req.op == increment_op
      && req.size == size_byte && req.count == 3'h2 |=> refused_q ##1 !memWr_q.we)
      else $error("byte increment by two accepted");
   a_adds_long_only: assert property (reqValid && !load.en && req.size != size_long
      && req.op inside {address_add_op, address_sub_op}
      |=> refused_q && regs_q[$past(dstIdx)] == $past(dstWide))
      else $error("address add accepted at short size");
   a_mul_word_value: assert property (reqValid && req.op == unsigned_multiply_op
      && req.size == size_word && !load.en |=> regs_q[$past(dstIdx)] ==
      ({16'h0000, $past(dstWide[15:0])} * {16'h0000, $past(opB[15:0])}))
      else $error("word multiply result wrong");

   c_divide_done: cover property (reqValid && req.op == signed_divide_op ##1 done_q);
   c_decimal_adjust: cover property (reqValid && req.op == decimal_adjust_add_op ##1 ccr_q.c);
   c_rotate_carry: cover property (reqValid && req.op == rotate_right_carry_op
      && req.count == 3'h2);
   c_tas_write: cover property (memWr_q.we);

endmodule

// File: pkg/alu_pkg.sv
// shared types and constants of the integer arithmetic, logic and shift unit
package alu_pkg;

   localparam int REG_COUNT = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 4;
   localparam int RESULT_LATENCY = 1;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [2:0] TAS_BIT = 3'h7;
   localparam logic [7:0] TAS_SET_MASK = 8'h80;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
   localparam logic [7:0] BCD_LOW_ADJ = 8'h06;
   localparam logic [7:0] BCD_HIGH_ADJ = 8'h60;
   localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
   localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
   localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {size_byte, size_word, size_long} size_type;

   typedef enum logic [4:0] {
      add_op, sub_op, add_with_carry_op, sub_with_carry_op, increment_op, decrement_op,
      address_add_op, address_sub_op, decimal_adjust_add_op, decimal_adjust_sub_op,
      unsigned_multiply_op, signed_multiply_op, unsigned_divide_op, signed_divide_op,
      compare_op, negate_op, zero_extend_op, sign_extend_op, test_and_set_op,
      and_op, or_op, xor_op, not_op,
      arith_left_shift_op, arith_right_shift_op, logic_left_shift_op, logic_right_shift_op,
      rotate_left_op, rotate_right_op, rotate_left_carry_op, rotate_right_carry_op
   } op_type;

   // one instruction: byte idx 0-7 high halves, 8-15 low; word 0-7 low, 8-15 upper
   typedef struct packed {
      op_type op;
      size_type size;
      logic [3:0] dst;
      logic [3:0] src;
      logic useImm;
      logic [31:0] imm;
      logic [2:0] count;
   } req_type;

   // condition_code_register flags used by this unit
   typedef struct packed {
      logic h;
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_type;

   localparam flags_type FLAGS_RESET = 5'h00;

   typedef struct packed {
      logic en;
      logic [2:0] idx;
      logic [31:0] data;
   } load_type;

   typedef struct packed {
      logic we;
      logic [31:0] addr;
      logic [7:0] data;
   } mem_type;

endpackage

// File: core/mul_div_unit.sv
// combinational multiplier and divider for byte and word operands
`timescale 1ns/10ps
module mul_div_unit (
   input wire logic signedMode,
   input wire logic wordMode,
   input wire logic [31:0] left,
   input wire logic [15:0] right,
   output logic [31:0] product,
   output logic [15:0] quotient,
   output logic [15:0] remainder,
   output logic divZero
);
   import alu_pkg::*;

   logic [31:0] dividend;
   logic [31:0] divisor;
   logic [31:0] quo;
   logic [31:0] rem;
   logic [31:0] mulA;
   logic [31:0] mulB;

   // =====================================================
   // operand widening
   always_comb begin
      if (wordMode) begin
         dividend = signedMode ? left : left;
         divisor = signedMode ? {{16{right[15]}}, right} : {16'h0000, right};
         mulA = signedMode ? {{16{left[15]}}, left[15:0]} : {16'h0000, left[15:0]};
      end else begin
         dividend = signedMode ? {{16{left[15]}}, left[15:0]} : {16'h0000, left[15:0]};
         divisor = signedMode ? {{24{right[7]}}, right[7:0]} : {24'h00_0000, right[7:0]};
         mulA = signedMode ? {{24{left[7]}}, left[7:0]} : {24'h00_0000, left[7:0]};
      end
      mulB = divisor;
   end

   // =====================================================
   // arithmetic; a zero divisor forces quotient and remainder to zero so no unknown leaks out
   always_comb begin
      divZero = (divisor == 32'h0000_0000);
      if (divZero) begin
         quo = 32'h0000_0000;
         rem = 32'h0000_0000;
      end else if (signedMode) begin
         quo = 32'($signed(dividend) / $signed(divisor));
         rem = 32'($signed(dividend) % $signed(divisor));
      end else begin
         quo = dividend / divisor;
         rem = dividend % divisor;
      end
      product = 32'(mulA * mulB);
      if (!wordMode) begin
         product = {16'h0000, product[15:0]};
      end
      quotient = wordMode ? quo[15:0] : {8'h00, quo[7:0]};
      remainder = wordMode ? rem[15:0] : {8'h00, rem[7:0]};
   end

endmodule

// File: verif/tb_top.sv
// self-checking bench for the integer arithmetic, logic and shift unit
`timescale 1ns/10ps
module tb_top;
   import alu_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic reqValid = 1'b0;
   req_type req = '0;
   logic [7:0] memByte = 8'h00;
   load_type load = '0;
   logic [2:0] readIdx = 3'h0;
   logic done;
   logic refused;
   flags_type condition_code_register;
   logic [31:0] readData;
   mem_type memWr;
   mem_type memSeen;
   int num_errors = 0;
   int checks_done = 0;

   cpu_arith_logic_shift_unit DUT (.mclk(mclk), .resetn(resetn), .reqValid(reqValid),
      .req(req), .memByte(memByte), .load(load), .readIdx(readIdx), .done(done),
      .refused(refused), .condition_code_register(condition_code_register), .readData(readData), .memWr(memWr));

   initial begin
      forever #20 mclk = ~mclk;
   end

   // =========================================
   // shared tasks
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic ld(logic [2:0] i, logic [31:0] d);
      @(posedge mclk);
      load <= '{1'b1, i, d};
      @(posedge mclk);
      load <= '0;
   endtask

   // one instruction; a nonzero immediate selects the immediate operand
   task automatic ex(op_type o, size_type s, logic [3:0] d, logic [3:0] sr = 4'h0,
         logic [31:0] im = 32'h0, logic [2:0] c = 3'h0, logic bad = 1'b0);
      @(posedge mclk);
      reqValid <= 1'b1;
      req <= '{o, s, d, sr, |im, im, c};
      @(posedge mclk);
      reqValid <= 1'b0;
      #1;
      memSeen = memWr;
      chk("done", 32'(done), 32'(!bad));
      chk("refused", 32'(refused), 32'(bad));
   endtask

   task automatic rd(logic [2:0] i, logic [31:0] e);
      @(posedge mclk);
      readIdx <= i;
      repeat (2) @(posedge mclk);
      #1;
      chk("readData", readData, e);
   endtask

   task automatic fl(logic [4:0] m, logic [4:0] e);
      chk("ccr", 32'(condition_code_register & m), 32'(e));
   endtask

   // =========================================
   // scenarios
   task automatic t_arith;
      ld(0, 32'h7FFF_FFFF);
      ld(1, 32'h1);
      ex(add_op, size_long, 4'h0, 4'h1);
      fl(5'h0A, 5'h0A);
      ex(sub_op, size_byte, 4'h8, 4'h0, 32'h1);
      fl(5'h01, 5'h01);
      ex(add_with_carry_op, size_byte, 4'h8, 4'h0, 32'h10);
      rd(0, 32'h8000_0010);
      ex(add_with_carry_op, size_word, 4'h0, 4'h1, 32'h0, 3'h0, 1'b1);
      ld(2, 32'h1234_00FF);
      ex(increment_op, size_byte, 4'hA, 4'h0, 32'h0, 3'h2, 1'b1);
      ex(increment_op, size_word, 4'h2, 4'h0, 32'h0, 3'h2);
      ex(decrement_op, size_long, 4'h2, 4'h0, 32'h0, 3'h1);
      rd(2, 32'h1234_0100);
      ex(address_add_op, size_long, 4'h2, 4'h0, 32'h0, 3'h4);
      ex(address_sub_op, size_long, 4'h2, 4'h0, 32'h0, 3'h3, 1'b1);
      ex(address_sub_op, size_word, 4'h2, 4'h0, 32'h0, 3'h1, 1'b1);
      rd(2, 32'h1234_0104);
      ld(4, 32'h9);
      ex(add_op, size_byte, 4'hC, 4'h0, 32'h1);
      ex(decimal_adjust_add_op, size_byte, 4'hC);
      rd(4, 32'h10);
   endtask

   task automatic t_muldiv;
      ld(5, 32'hFF);
      ld(6, 32'hFFFF);
      ex(unsigned_multiply_op, size_byte, 4'h5, 4'hE);
      rd(5, 32'hFE01);
      ex(signed_multiply_op, size_word, 4'h5, 4'h6);
      rd(5, 32'h1FF);
      ex(unsigned_multiply_op, size_word, 4'h5, 4'h6);
      rd(5, 32'h01FE_FE01);
      ld(5, 32'd100);
      ld(6, 32'h7);
      ex(unsigned_divide_op, size_word, 4'h5, 4'h6);
      rd(5, 32'h0002_000E);
      ld(5, 32'hFFF9);
      ld(6, 32'h2);
      ex(signed_divide_op, size_byte, 4'h5, 4'hE);
      ld(6, 32'h0);
      ex(signed_divide_op, size_byte, 4'h5, 4'hE, 32'h0, 3'h0, 1'b1);
      rd(5, 32'hFFFD);
   endtask

   task automatic t_misc;
      ld(7, 32'h5);
      ex(compare_op, size_long, 4'h7, 4'h0, 32'h5);
      fl(5'h04, 5'h04);
      ex(negate_op, size_long, 4'h7);
      rd(7, 32'hFFFF_FFFB);
      ex(zero_extend_op, size_long, 4'h7);
      ex(zero_extend_op, size_word, 4'h7);
      ex(sign_extend_op, size_word, 4'h7);
      rd(7, 32'h0000_FFFB);
      ld(1, 32'h1000);
      @(posedge mclk);
      memByte <= 8'h35;
      ex(test_and_set_op, size_byte, 4'h1);
      chk("memWr", {memSeen.we, memSeen.addr[22:0], memSeen.data}, 32'h8010_00B5);
      ex(test_and_set_op, size_byte, 4'h2, 4'h0, 32'h0, 3'h0, 1'b1);
      chk("memWr.we", 32'(memSeen.we), 32'h0);
      ld(0, 32'hF0F0_F0F0);
      ld(1, 32'h0FF0_0FF0);
      ex(and_op, size_long, 4'h0, 4'h1);
      ex(or_op, size_word, 4'h0, 4'h0, 32'hF);
      ex(xor_op, size_byte, 4'h0, 4'h0, 32'hFF);
      ex(not_op, size_word, 4'h8);
      rd(0, 32'hFF0F_FFFF);
      ex(not_op, size_long, 4'h0);
      rd(0, 32'h00F0_0000);
   endtask

   task automatic t_shift;
      ld(2, 32'h8000_0001);
      ex(arith_right_shift_op, size_long, 4'h2, 4'h0, 32'h0, 3'h1);
      rd(2, 32'hC000_0000);
      ex(logic_right_shift_op, size_long, 4'h2, 4'h0, 32'h0, 3'h2);
      ex(arith_left_shift_op, size_long, 4'h2, 4'h0, 32'h0, 3'h3, 1'b1);
      rd(2, 32'h3000_0000);
      ex(rotate_left_op, size_long, 4'h2, 4'h0, 32'h0, 3'h1);
      ex(rotate_left_op, size_long, 4'h2, 4'h0, 32'h0, 3'h2);
      rd(2, 32'h8000_0001);
      ex(rotate_right_op, size_long, 4'h2, 4'h0, 32'h0, 3'h1);
      ex(logic_left_shift_op, size_long, 4'h2, 4'h0, 32'h0, 3'h1);
      ex(rotate_right_carry_op, size_long, 4'h2, 4'h0, 32'h0, 3'h1);
      ex(rotate_left_carry_op, size_long, 4'h2, 4'h0, 32'h0, 3'h2);
      rd(2, 32'h1);
      fl(5'h01, 5'h01);
   endtask

   // =========================================
   // verdict, main sequence and watchdog
   task automatic report_and_stop;
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      t_arith();
      t_muldiv();
      t_misc();
      t_shift();
      report_and_stop();
   end

   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end
endmodule
